//--- twc_map.vh
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
// Summary of operation
// RL1 - sda falling while scl high is a start; transfers begin there
// RL2 - sda rising while scl high is a stop; it ends the transfer
// RL3 - both lines high means idle; nobody pulls low then
// RL4 - a repeated start restarts address decoding
// RL5 - any number of data bytes until stop or repeated start
// RL6 - the receiver pulls sda low through the ninth clock high phase
// RL7 - on an address mismatch sda stays high in the acknowledge slot
// RL8 - a slave unable to take more bytes leaves sda high; master stops
// RL9 - general settings: pin or serial select bit 7, sleep bit 6, reserved bit 0
// RL10 - device control: diagnostic bit 7, loopbacks c b a bits 6-4, lane selects 3-0
// RL11 - port control: lane 0..3 output off bits 7..4, squelch 3, reserved 2, agc off 0
// RL12 - port input: input sleep bit 7, reserved 6-4, peaking code 3-0
// RL13 - port output: swing field bits 5-4, receive gain bits 1-0
// RL14 - polarity ab: port b lanes bits 7-4, port a lanes bits 3-0
// RL15 - polarity c: port c lanes in bits 3-0, read and write
// RL16 - lane enables: one bit per lane in bits 3-0
// RL17 - one reserved register read only, one read write, neither acts
// RL18 - address is four zeros, three strap bits, then direction; zero writes
// RL19 - lane select zero routes port c to a, one routes to b, per lane
// RL20 - register address auto increments; unmapped writes dropped, reads zero
// RL21 - reads return the register at the current register address
`define TWC_ADDR_HI     4'h0
`define TWC_REG_GEN     8'h00
`define TWC_REG_DEV     8'h01
`define TWC_REG_PA_CTL  8'h02
`define TWC_REG_PA_IN   8'h03
`define TWC_REG_PA_OUT  8'h04
`define TWC_REG_PB_CTL  8'h06
`define TWC_REG_PB_IN   8'h07
`define TWC_REG_PB_OUT  8'h08
`define TWC_REG_PC_CTL  8'h0A
`define TWC_REG_PC_IN   8'h0B
`define TWC_REG_PC_OUT  8'h0C
`define TWC_REG_RSV_RW  8'h0D
`define TWC_REG_RSV_RO  8'h0F
`define TWC_REG_POL_AB  8'h10
`define TWC_REG_POL_C   8'h11
`define TWC_REG_LANE_EN 8'h12
`define TWC_MASK_GEN    8'hC1
`define TWC_MASK_CTL    8'hFD
`define TWC_MASK_IN     8'hFF
`define TWC_MASK_OUT    8'h33
`define TWC_MASK_LOW4   8'h0F
`define TWC_MASK_ALL    8'hFF
`define TWC_RST_VAL     8'h00
`define TWC_RSV_RO_VAL  8'h00
`define TWC_BIT_LAST    3'h7
`define TWC_BIT_ZERO    3'h0
`endif

//--- twc_master.sv
module twc_master (
  // bus
  output logic scl,
  output logic sda_m,
  input  wire  sda
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start
  task automatic go();
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask
  // stop, then idle with both lines high
  task automatic halt();
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #(4 * Q);
  endtask
  // byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] t, input logic a, output logic [7:0] r, output logic k);
    for (int i = 0; i < 9; i++) begin
      #Q sda_m = (i < 8) ? t[7 - i] : a;
      #Q scl = 1'b1;
      #(2 * Q);
      if (i < 8) r = {r[6:0], sda};
      else k = sda;
      scl = 1'b0;
    end
  endtask
endmodule // twc_master

//--- twc_slave.v
`include "twc_map.vh"
module twc_slave (
  // clock, reset, enable
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  // two-wire pins
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  // address straps
  input  wire [2:0] addr_strap,
  // register contents
  output reg  [7:0] general_settings_q,
  output reg  [7:0] device_control_q,
  output reg  [7:0] port_a_control_q,
  output reg  [7:0] port_a_input_q,
  output reg  [7:0] port_a_output_q,
  output reg  [7:0] port_b_control_q,
  output reg  [7:0] port_b_input_q,
  output reg  [7:0] port_b_output_q,
  output reg  [7:0] port_c_control_q,
  output reg  [7:0] port_c_input_q,
  output reg  [7:0] port_c_output_q,
  output reg  [7:0] reserved_rw_q,
  output reg  [7:0] lane_polarity_ab_q,
  output reg  [7:0] lane_polarity_c_q,
  output reg  [7:0] lane_enables_q,
  // lane routing and busy flag
  output reg  [3:0] lane_port_choice_q,
  output reg        busy_q
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_REG  = 5'b00100;
  localparam ST_WR   = 5'b01000;
  localparam ST_RD   = 5'b10000;

  reg [1:0] scl_s_q, sda_s_q;
  reg       scl_p_q, sda_p_q;
  reg [4:0] st_q;
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  reg       ack_ph_q;
  reg       acked_q;
  reg       rd_q;
  reg [7:0] ptr_q;
  reg       in_byte_q;
  reg [2:0] strap_s1_q;
  reg [2:0] strap_s2_q;

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start_c  = scl & scl_p_q & sda_p_q & ~sda; // [RL1] [RL4]
  wire stop_c   = scl & scl_p_q & ~sda_p_q & sda; // [RL2]
  wire [7:0] byte_in = {sh_q[6:0], sda};

  // mask of writable bits per address, zero when unmapped
  function [7:0] wr_mask;
    input [7:0] a;
    begin
      case (a)
        `TWC_REG_GEN:     wr_mask = `TWC_MASK_GEN;
        `TWC_REG_DEV:     wr_mask = `TWC_MASK_ALL;
        `TWC_REG_PA_CTL,
        `TWC_REG_PB_CTL,
        `TWC_REG_PC_CTL:  wr_mask = `TWC_MASK_CTL;
        `TWC_REG_PA_IN,
        `TWC_REG_PB_IN,
        `TWC_REG_PC_IN:   wr_mask = `TWC_MASK_IN;
        `TWC_REG_PA_OUT,
        `TWC_REG_PB_OUT,
        `TWC_REG_PC_OUT:  wr_mask = `TWC_MASK_OUT;
        `TWC_REG_RSV_RW:  wr_mask = `TWC_MASK_ALL;
        `TWC_REG_POL_AB:  wr_mask = `TWC_MASK_ALL;
        `TWC_REG_POL_C:   wr_mask = `TWC_MASK_LOW4;
        `TWC_REG_LANE_EN: wr_mask = `TWC_MASK_LOW4;
        default:          wr_mask = `TWC_RST_VAL;
      endcase
    end
  endfunction

  reg [7:0] rd_data;
  always @* begin
    case (ptr_q) // [RL21]
      `TWC_REG_GEN:     rd_data = general_settings_q;
      `TWC_REG_DEV:     rd_data = device_control_q;
      `TWC_REG_PA_CTL:  rd_data = port_a_control_q;
      `TWC_REG_PA_IN:   rd_data = port_a_input_q;
      `TWC_REG_PA_OUT:  rd_data = port_a_output_q;
      `TWC_REG_PB_CTL:  rd_data = port_b_control_q;
      `TWC_REG_PB_IN:   rd_data = port_b_input_q;
      `TWC_REG_PB_OUT:  rd_data = port_b_output_q;
      `TWC_REG_PC_CTL:  rd_data = port_c_control_q;
      `TWC_REG_PC_IN:   rd_data = port_c_input_q;
      `TWC_REG_PC_OUT:  rd_data = port_c_output_q;
      `TWC_REG_RSV_RW:  rd_data = reserved_rw_q;
      `TWC_REG_RSV_RO:  rd_data = `TWC_RSV_RO_VAL; // [RL17]
      `TWC_REG_POL_AB:  rd_data = lane_polarity_ab_q;
      `TWC_REG_POL_C:   rd_data = lane_polarity_c_q;
      `TWC_REG_LANE_EN: rd_data = lane_enables_q;
      default:          rd_data = `TWC_RST_VAL; // [RL20]
    endcase
  end

  // writes a masked byte to the pointed register
  task put;
    input [7:0] a;
    input [7:0] d;
    reg   [7:0] v;
    begin
      v = d & wr_mask(a);
      case (a)
        `TWC_REG_GEN:     general_settings_q <= v; // [RL9]
        `TWC_REG_DEV:     device_control_q   <= v; // [RL10]
        `TWC_REG_PA_CTL:  port_a_control_q   <= v; // [RL11]
        `TWC_REG_PA_IN:   port_a_input_q     <= v; // [RL12]
        `TWC_REG_PA_OUT:  port_a_output_q    <= v; // [RL13]
        `TWC_REG_PB_CTL:  port_b_control_q   <= v; // [RL11]
        `TWC_REG_PB_IN:   port_b_input_q     <= v; // [RL12]
        `TWC_REG_PB_OUT:  port_b_output_q    <= v; // [RL13]
        `TWC_REG_PC_CTL:  port_c_control_q   <= v; // [RL11]
        `TWC_REG_PC_IN:   port_c_input_q     <= v; // [RL12]
        `TWC_REG_PC_OUT:  port_c_output_q    <= v; // [RL13]
        `TWC_REG_RSV_RW:  reserved_rw_q      <= v; // [RL17]
        `TWC_REG_POL_AB:  lane_polarity_ab_q <= v; // [RL14]
        `TWC_REG_POL_C:   lane_polarity_c_q  <= v; // [RL15]
        `TWC_REG_LANE_EN: lane_enables_q     <= v; // [RL16]
        default:          ;
      endcase
    end
  endtask

  always @(posedge clk) begin
    if (srst) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      sh_q <= `TWC_RST_VAL;
      bit_q <= `TWC_BIT_ZERO;
      ack_ph_q <= 1'b0;
      acked_q <= 1'b0;
      rd_q <= 1'b0;
      ptr_q <= `TWC_RST_VAL;
      in_byte_q <= 1'b0;
      strap_s1_q <= `TWC_BIT_ZERO;
      strap_s2_q <= `TWC_BIT_ZERO;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      busy_q <= 1'b0;
      lane_port_choice_q <= 4'h0;
      general_settings_q <= `TWC_RST_VAL;
      device_control_q   <= `TWC_RST_VAL;
      port_a_control_q   <= `TWC_RST_VAL;
      port_a_input_q     <= `TWC_RST_VAL;
      port_a_output_q    <= `TWC_RST_VAL;
      port_b_control_q   <= `TWC_RST_VAL;
      port_b_input_q     <= `TWC_RST_VAL;
      port_b_output_q    <= `TWC_RST_VAL;
      port_c_control_q   <= `TWC_RST_VAL;
      port_c_input_q     <= `TWC_RST_VAL;
      port_c_output_q    <= `TWC_RST_VAL;
      reserved_rw_q      <= `TWC_RST_VAL;
      lane_polarity_ab_q <= `TWC_RST_VAL;
      lane_polarity_c_q  <= `TWC_RST_VAL;
      lane_enables_q     <= `TWC_RST_VAL;
    end else if (ce) begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl;
      sda_p_q <= sda;
      strap_s1_q <= addr_strap;
      strap_s2_q <= strap_s1_q;
      lane_port_choice_q <= device_control_q[3:0]; // [RL19]
      busy_q <= (st_q != ST_IDLE);
      if (start_c) begin
        st_q <= ST_ADDR; // [RL1] [RL4]
        bit_q <= `TWC_BIT_ZERO;
        ack_ph_q <= 1'b0;
        in_byte_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_q <= ST_IDLE; // [RL2] [RL3]
        sda_oe <= 1'b0;
      end else if (st_q != ST_IDLE) begin
        if (scl_rise && !ack_ph_q) begin
          sh_q <= byte_in;
          bit_q <= bit_q + 3'h1;
          in_byte_q <= 1'b1;
        end
        if (scl_rise && ack_ph_q && st_q == ST_RD)
          acked_q <= ~sda;
        if (scl_fall) begin
          if (ack_ph_q) begin
            ack_ph_q <= 1'b0;
            sda_oe <= 1'b0;
            if (st_q == ST_RD) begin
              if (acked_q) begin
                sda_o <= 1'b0;
                sda_oe <= ~rd_data[7];
                sh_q <= rd_data;
                ptr_q <= ptr_q + 8'h01; // [RL20]
              end else
                st_q <= ST_IDLE; // master nack ends the read
            end
          end else if (bit_q == `TWC_BIT_ZERO && in_byte_q) begin
            // the fall that closes a start holds no bit, so it is skipped
            ack_ph_q <= 1'b1;
            in_byte_q <= 1'b0;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            case (st_q)
              ST_ADDR: begin
                if (sh_q[7:1] == {`TWC_ADDR_HI, strap_s2_q}) begin // [RL18]
                  sda_oe <= 1'b1; // [RL6]
                  rd_q <= sh_q[0];
                  acked_q <= 1'b1;
                  st_q <= sh_q[0] ? ST_RD : ST_REG;
                end else
                  st_q <= ST_IDLE; // [RL7]
              end
              ST_REG: begin
                sda_oe <= 1'b1; // [RL6]
                ptr_q <= sh_q;
                st_q <= ST_WR;
              end
              ST_WR: begin
                sda_oe <= 1'b1; // [RL5] [RL8]
                put(ptr_q, sh_q);
                ptr_q <= ptr_q + 8'h01; // [RL20]
              end
              ST_RD: begin
                sda_oe <= 1'b0;
              end
              default: st_q <= ST_IDLE;
            endcase
          end else if (st_q == ST_RD) begin
            sda_o <= 1'b0;
            // sh_q shifts on every data-bit rise, so its top bit is the next one out
            sda_oe <= ~sh_q[`TWC_BIT_LAST];
          end
        end
      end
    end
  end
endmodule // twc_slave

//--- twc_slave_chk.sv
module twc_slave_chk (
  // clock and reset
  input wire       clk,
  input wire       srst,
  // bus pins
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_oe,
  // state
  input wire       busy_q,
  input wire [7:0] general_settings_q,
  input wire [7:0] device_control_q,
  input wire [7:0] port_a_output_q,
  input wire [3:0] lane_port_choice_q
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  idle_quiet_a: assert property (!busy_q [*3] |-> !sda_oe)
    else $error("sda pulled while idle");
  ack_steady_a: assert property (scl_i [*6] |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  start_busy_a: assert property (scl_i && $fell(sda_i) |-> ##[1:6] busy_q)
    else $error("start not seen");
  stop_idle_a: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !busy_q)
    else $error("stop not seen");
  gen_mask_a: assert property ((general_settings_q & 8'h3E) == 8'h00)
    else $error("general unused bits set");
  out_mask_a: assert property ((port_a_output_q & 8'hCC) == 8'h00)
    else $error("output unused bits set");
  lane_route_a: assert property (1'b1 |=> lane_port_choice_q == $past(device_control_q[3:0]))
    else $error("lane choice lags");
  regs_hold_a: assert property (!busy_q [*2] |=> $stable({general_settings_q, device_control_q}))
    else $error("register moved while idle");
endmodule // twc_slave_chk

//--- twc_slave_tb_top.sv
module twc_slave_tb_top;
  timeunit 1ns;
  timeprecision 10ps;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic       scl, sda_m, sda_o, sda_oe, busy_q, k;
  logic [7:0] gs, dc, pac, pai, pao, pbc, pbi, pbo, pcc, pci, pco, rsv, pab, pc, le, r;
  logic [3:0] lp;
  wire        sda = sda_m & (~sda_oe | sda_o);
  int         fails = 0;
  int         samples_checked = 0;
  localparam logic [15:0] MAP [17] = '{16'h00C1, 16'h01FF, 16'h02FD, 16'h03FF, 16'h0433,
    16'h06FD, 16'h07FF, 16'h0833, 16'h0AFD, 16'h0BFF, 16'h0C33, 16'h0DFF, 16'h0F00,
    16'h10FF, 16'h110F, 16'h120F, 16'h0500};
  always #2.5 clk = ~clk;
  twc_slave uut (.clk, .srst, .ce(1'b1), .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
    .addr_strap(strap), .general_settings_q(gs), .device_control_q(dc),
    .port_a_control_q(pac), .port_a_input_q(pai), .port_a_output_q(pao),
    .port_b_control_q(pbc), .port_b_input_q(pbi), .port_b_output_q(pbo),
    .port_c_control_q(pcc), .port_c_input_q(pci), .port_c_output_q(pco),
    .reserved_rw_q(rsv), .lane_polarity_ab_q(pab), .lane_polarity_c_q(pc),
    .lane_enables_q(le), .lane_port_choice_q(lp), .busy_q);
  twc_master m (.scl, .sda_m, .sda);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic ek);
    m.xfer(b, 1'b1, r, k);
    chk({7'h0, k}, {7'h0, ek});
  endtask
  task automatic hdr(input logic [7:0] a);
    m.go();
    put({4'h0, strap, 1'b0}, 1'b0);
    put(a, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hdr(a);
    put(d, 1'b0);
    m.halt();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e [$]);
    hdr(a);
    m.go();
    put({4'h0, strap, 1'b1}, 1'b0);
    foreach (e[i]) begin
      m.xfer(8'hFF, i == e.size() - 1, r, k);
      chk(r, e[i]);
    end
    m.halt();
  endtask
  task automatic sc_map();
    chk(gs | dc | pac | pai | pao | pbc | pbi | pco | rsv | pab | pc | le, 8'h00);
    foreach (MAP[i]) begin
      wr(MAP[i][15:8], 8'hFF);
      rd(MAP[i][15:8], {MAP[i][7:0]});
    end
    chk({4'h0, lp}, 8'h0F);
    chk(pbo | pcc | pci, 8'hFF);
    $display("test map done");
  endtask
  task automatic sc_burst();
    hdr(8'h10);
    put(8'h5A, 1'b0);
    put(8'hA5, 1'b0);
    put(8'h03, 1'b0);
    m.halt();
    chk(pab, 8'h5A);
    chk(pc, 8'h05);
    chk(le, 8'h03);
    rd(8'h10, {8'h5A, 8'h05, 8'h03});
    $display("test burst done");
  endtask
  task automatic sc_strap();
    @(posedge clk) #1 strap = 3'h5;
    m.go();
    put(8'h00, 1'b1);
    put(8'h12, 1'b1);
    m.halt();
    chk(le, 8'h03);
    wr(8'h12, 8'h0C);
    chk(le, 8'h0C);
    $display("test strap done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    sc_map();
    sc_burst();
    sc_strap();
    final_report();
  end
endmodule // twc_slave_tb_top
bind twc_slave twc_slave_chk chk (.clk, .srst, .scl_i, .sda_i, .sda_oe, .busy_q,
  .general_settings_q, .device_control_q, .port_a_output_q, .lane_port_choice_q);
